// [design/srg_map.svh]
// register map, field positions and reset values of the rate generator
`ifndef SRG_MAP_SVH
`define SRG_MAP_SVH
// ==========================================================
// register offsets (byte addresses)
`define SRG_CFG_ADDR 8'h00
`define SRG_CTL_ADDR 8'h04
`define SRG_STAT_ADDR 8'h08
// ==========================================================
// rate_gen_config fields
`define SRG_CFG_RESET 32'h2000_0001
`define SRG_RESYNC_BIT 31
`define SRG_EDGE_BIT 30
`define SRG_SRC_BIT 29
`define SRG_FGMODE_BIT 28
`define SRG_PER_HI 27
`define SRG_PER_LO 16
`define SRG_WID_HI 15
`define SRG_WID_LO 8
`define SRG_DIV_HI 7
`define SRG_DIV_LO 0
// ==========================================================
// control register fields
`define SRG_CTL_RESET 32'h0000_0000
`define SRG_CTL_MASK 32'h0000_007F
`define SRG_CTL_SRG_RESET_N 0
`define SRG_CTL_FRAME_GEN_RESET_N 1
`define SRG_CTL_RX_RESET_N 2
`define SRG_CTL_TX_RESET_N 3
`define SRG_CTL_FSXDIR 4
`define SRG_CTL_RXCLKDIR 5
`define SRG_CTL_TXCLKDIR 6
// ==========================================================
// status register fields and timing
`define SRG_STAT_CLK 0
`define SRG_STAT_FSG 1
`define SRG_STAT_RUN 2
`define SRG_WARM_LAST 4'h7
`endif

// [design/srg_pkg.sv]
// types shared by the rate generator design
package srg_pkg;
  // frame generator states, gray coded along idle, warm-up, run
  typedef enum logic [1:0] {
    FG_IDLE = 2'b00,
    FG_WARM = 2'b01,
    FG_RUN = 2'b11
  } frame_state_t;
endpackage

// [design/serial_port_rate_generator.sv]
// bit clock and frame pulse generator of a buffered serial port
//
// Operation
// - resync off: clock restarts only on a frame sync rise that meets a tick
// - resync on: restart clock, pulse on frame sync
// - resync and edge select only for external source
// - edge select 0 rising, 1 falling external edge
// - source select 0 external, 1 internal, reset 1
// - tx frame: copy pulse or generated frame pulse
// - period field plus one sets frame spacing
// - width field plus one sets pulse width
// - bit clock is input over divisor plus one
// - odd divisor even duty; zero holds high; even 2p: p+1 high
// - generator reset holds clock and pulse low
// - enabled clock goes high on next input edge
// - resync off: first frame pulse after eight bit clocks
// - clock direction 1 drives section clock from generator
// - updates on the selected edge of selected input clock
// - divider counter from divisor clocks frame counters
// - width and period count down in parallel, period only with resync off
// - frame sync rise restarts clock, starting high
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "srg_map.svh"

module serial_port_rate_generator (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // link side inputs
  input wire logic ext_srg_clock_in,
  input wire logic rx_frame_sync,
  input wire logic tx_copy_pulse,
  // generator outputs
  output logic gen_bit_clock,
  output logic gen_frame_pulse,
  // section enables
  output logic rx_reset_n,
  output logic tx_reset_n,
  // pin drivers
  output logic tx_frame_sync_out,
  output logic tx_frame_sync_oe,
  output logic rx_data_clock_out,
  output logic rx_data_clock_oe,
  output logic tx_data_clock_out,
  output logic tx_data_clock_oe
);

  // ==========================================================
  // registers
  logic [31:0] cfg_q;
  logic [31:0] ctl_q;
  logic [31:0] rdata_q;
  logic [7:0] ph_q;
  logic clk_q;
  logic run_q;
  logic pend_q;
  srg_pkg::frame_state_t state_q;
  logic [3:0] warm_q;
  logic [8:0] fw_q;
  logic [12:0] fp_q;
  logic fsg_q;
  logic txfs_q;

  // configuration views
  logic resync_cfg;
  logic edge_sel;
  logic src_int;
  logic fg_mode;
  logic [11:0] per;
  logic [7:0] wid;
  logic [7:0] div;
  logic srg_reset_n_n;
  logic frame_gen_reset_n_n;
  assign resync_cfg = cfg_q[`SRG_RESYNC_BIT];
  assign edge_sel = cfg_q[`SRG_EDGE_BIT];
  assign src_int = cfg_q[`SRG_SRC_BIT];
  assign fg_mode = cfg_q[`SRG_FGMODE_BIT];
  assign per = cfg_q[`SRG_PER_HI:`SRG_PER_LO];
  assign wid = cfg_q[`SRG_WID_HI:`SRG_WID_LO];
  assign div = cfg_q[`SRG_DIV_HI:`SRG_DIV_LO];
  assign srg_reset_n_n = ctl_q[`SRG_CTL_SRG_RESET_N];
  assign frame_gen_reset_n_n = ctl_q[`SRG_CTL_FRAME_GEN_RESET_N];

  // ==========================================================
  // register port: writes, and read data valid only the cycle after
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q <= `SRG_CFG_RESET;
      ctl_q <= `SRG_CTL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `SRG_CFG_ADDR) cfg_q <= reg_wdata;
      if (reg_addr == `SRG_CTL_ADDR) ctl_q <= reg_wdata & `SRG_CTL_MASK;
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SRG_CFG_ADDR: rdata_q <= cfg_q;
        `SRG_CTL_ADDR: rdata_q <= ctl_q;
        `SRG_STAT_ADDR: rdata_q <= {29'h0000_0000, run_q, fsg_q, clk_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // synchronisers: a change counts when stages two and three agree
  logic [2:0] cks_q;
  logic [2:0] fsr_q;
  logic cks_lvl_q;
  logic fsr_lvl_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cks_q <= 3'h0;
      fsr_q <= 3'h0;
      cks_lvl_q <= 1'b0;
      fsr_lvl_q <= 1'b0;
    end else begin
      cks_q <= {cks_q[1:0], ext_srg_clock_in};
      fsr_q <= {fsr_q[1:0], rx_frame_sync};
      if (cks_q[1] == cks_q[2]) cks_lvl_q <= cks_q[2];
      if (fsr_q[1] == fsr_q[2]) fsr_lvl_q <= fsr_q[2];
    end
  end

  // edges of the filtered levels
  logic ext_rise;
  logic ext_fall;
  logic fs_rise;
  assign ext_rise = (cks_q[1] == cks_q[2]) && cks_q[2] && !cks_lvl_q;
  assign ext_fall = (cks_q[1] == cks_q[2]) && !cks_q[2] && cks_lvl_q;
  assign fs_rise = (fsr_q[1] == fsr_q[2]) && fsr_q[2] && !fsr_lvl_q;

  // ==========================================================
  // input clock selection: one tick per selected input edge
  logic tick;
  logic resync_on;
  assign tick = src_int ? 1'b1 : (edge_sel ? ext_fall : ext_rise);
  assign resync_on = !src_int && resync_cfg;

  // pending frame sync, caught between ticks; the set wins over the tick clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (!resync_on || !srg_reset_n_n) begin
      pend_q <= 1'b0;
    end else if (fs_rise) begin
      pend_q <= 1'b1;
    end else if (tick) begin
      pend_q <= 1'b0;
    end
  end

  logic restart;
  assign restart = tick && run_q && (pend_q || fs_rise);

  // ==========================================================
  // first divider stage; high part is divisor/2 + 1 input cycles
  logic [8:0] hi_len;
  logic [7:0] ph_inc;
  logic bclk_rise;
  assign hi_len = {2'b00, div[7:1]} + 9'h001;
  assign ph_inc = ph_q + 8'h01;
  assign bclk_rise = srg_reset_n_n && tick && (!run_q || restart || ph_q == div);

  // divisor zero leaves the clock high: every input tick is a bit clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_q <= 8'h00;
      clk_q <= 1'b0;
      run_q <= 1'b0;
    end else if (!srg_reset_n_n) begin
      ph_q <= 8'h00;
      clk_q <= 1'b0;
      run_q <= 1'b0;
    end else if (tick) begin
      run_q <= 1'b1;
      if (bclk_rise) begin
        ph_q <= 8'h00;
        clk_q <= 1'b1;
      end else begin
        ph_q <= ph_inc;
        clk_q <= ({1'b0, ph_inc} < hi_len);
      end
    end
  end
  assign gen_bit_clock = clk_q;

  // ==========================================================
  // frame generator: warm-up of eight bit clocks, then counters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= srg_pkg::FG_IDLE;
      warm_q <= 4'h0;
      fw_q <= 9'h000;
      fp_q <= 13'h0000;
      fsg_q <= 1'b0;
    end else if (!srg_reset_n_n || !frame_gen_reset_n_n) begin
      state_q <= srg_pkg::FG_IDLE;
      warm_q <= 4'h0;
      fsg_q <= 1'b0;
    end else begin
      case (state_q)
        srg_pkg::FG_IDLE: begin
          state_q <= srg_pkg::FG_WARM;
          warm_q <= bclk_rise ? 4'h1 : 4'h0; // a rise here already counts
        end
        srg_pkg::FG_WARM: begin
          if (bclk_rise) begin
            if (warm_q == `SRG_WARM_LAST) begin
              state_q <= srg_pkg::FG_RUN;
              if (!resync_on) begin
                fsg_q <= 1'b1;
                fw_q <= {1'b0, wid};
                fp_q <= {1'b0, per};
              end
            end else begin
              warm_q <= warm_q + 4'h1;
            end
          end
        end
        srg_pkg::FG_RUN: begin
          if (bclk_rise) begin
            if (resync_on ? restart : (fp_q == 13'h0000)) begin
              fsg_q <= 1'b1;
              fw_q <= {1'b0, wid};
              fp_q <= {1'b0, per};
            end else begin
              if (!resync_on) fp_q <= fp_q - 13'h0001;
              if (fw_q == 9'h000) begin
                fsg_q <= 1'b0;
              end else begin
                fw_q <= fw_q - 9'h001;
              end
            end
          end
        end
        default: state_q <= srg_pkg::FG_IDLE;
      endcase
    end
  end
  assign gen_frame_pulse = fsg_q;

  // ==========================================================
  // transmit frame sync source, registered so the pin sees no glitch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txfs_q <= 1'b0;
    end else begin
      txfs_q <= fg_mode ? fsg_q : tx_copy_pulse;
    end
  end

  // pin drivers and section enables
  assign tx_frame_sync_oe = ctl_q[`SRG_CTL_FSXDIR];
  assign tx_frame_sync_out = ctl_q[`SRG_CTL_FSXDIR] && txfs_q;
  assign rx_data_clock_oe = ctl_q[`SRG_CTL_RXCLKDIR];
  assign rx_data_clock_out = ctl_q[`SRG_CTL_RXCLKDIR] && clk_q;
  assign tx_data_clock_oe = ctl_q[`SRG_CTL_TXCLKDIR];
  assign tx_data_clock_out = ctl_q[`SRG_CTL_TXCLKDIR] && clk_q;
  assign rx_reset_n = ctl_q[`SRG_CTL_RX_RESET_N];
  assign tx_reset_n = ctl_q[`SRG_CTL_TX_RESET_N];

  // ==========================================================
  // checks next to the logic
  a_reset_clk_low: assert property (@(posedge clock) disable iff (rst)
    !srg_reset_n_n |=> !gen_bit_clock && !gen_frame_pulse)
    else $error("generator outputs not low in generator reset");

  a_start_high: assert property (@(posedge clock) disable iff (rst)
    srg_reset_n_n && tick && !run_q |=> gen_bit_clock)
    else $error("bit clock did not start high");

  a_restart_high: assert property (@(posedge clock) disable iff (rst)
    restart && srg_reset_n_n |=> gen_bit_clock && ph_q == 8'h00)
    else $error("resync did not restart the bit clock high");

  a_duty_split: assert property (@(posedge clock) disable iff (rst)
    run_q |-> gen_bit_clock == ({1'b0, ph_q} < hi_len))
    else $error("bit clock high time wrong for divisor");

  a_phase_walk: assert property (@(posedge clock) disable iff (rst)
    srg_reset_n_n && run_q && tick && !restart && ph_q != div |=> ph_q == $past(ph_q) + 8'h01)
    else $error("divider phase did not advance by one");

  a_internal_tick: assert property (@(posedge clock) disable iff (rst)
    src_int |-> tick)
    else $error("internal source missed an input tick");

  a_edge_pick: assert property (@(posedge clock) disable iff (rst)
    !src_int && (edge_sel ? ext_rise : ext_fall) |-> !tick)
    else $error("external clock used on the wrong edge");

  a_free_run: assert property (@(posedge clock) disable iff (rst)
    !resync_on |=> !pend_q)
    else $error("frame sync pending while resync disabled");

  a_pulse_cause: assert property (@(posedge clock) disable iff (rst)
    $rose(gen_frame_pulse) |-> $past(state_q) != srg_pkg::FG_IDLE && $past(bclk_rise))
    else $error("frame pulse rose without a bit clock");

  a_sync_only: assert property (@(posedge clock) disable iff (rst)
    resync_on && state_q == srg_pkg::FG_RUN && !restart |=> !$rose(gen_frame_pulse))
    else $error("frame pulse without incoming frame sync");

  a_txfs_mode: assert property (@(posedge clock) disable iff (rst)
    tx_frame_sync_oe && fg_mode && $stable(cfg_q) && $stable(ctl_q)
    |=> tx_frame_sync_out == ($past(gen_frame_pulse) && tx_frame_sync_oe))
    else $error("transmit frame sync not following frame pulse");

  a_clock_route: assert property (@(posedge clock) disable iff (rst)
    rx_data_clock_oe |-> rx_data_clock_out == gen_bit_clock)
    else $error("receive clock not driven from bit clock");

endmodule // serial_port_rate_generator

// [verification/ext_serial_peer.sv]
// external serial peer: source clock and receive frame sync
`timescale 1ns/1ps
module ext_serial_peer #(
  parameter int HALF_NS = 80
) (
  // control from bench
  input wire logic run,
  input wire logic fs_go,
  // pins toward the port
  output logic ext_clk,
  output logic frame_sync
);
  // ==========================================================
  // source clock, parked low while not running
  initial begin
    ext_clk = 1'b0;
    forever begin
      #(HALF_NS);
      ext_clk = run ? ~ext_clk : 1'b0;
    end
  end
  // frame sync one clock wide, launched on a falling edge so rising-edge sampling is clean
  initial begin
    frame_sync = 1'b0;
    forever begin
      @(posedge fs_go);
      @(negedge ext_clk);
      frame_sync = 1'b1;
      @(negedge ext_clk);
      frame_sync = 1'b0;
    end
  end
endmodule // ext_serial_peer

// [verification/tb_serial_port_rate_generator.sv]
// self-checking bench of the rate generator
`timescale 1ns/1ps
`include "srg_map.svh"
module tb_serial_port_rate_generator;
  // ==========================================================
  // signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_copy_pulse = 1'b0;
  logic run = 1'b0;
  logic fs_go = 1'b0;
  logic [31:0] reg_rdata;
  logic ext_clk, frame_sync, bclk, fpulse, rx_reset_n, tx_reset_n;
  logic fs_out, fs_oe, rck, rck_oe, tck, tck_oe;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  int hi, lo;
  logic [31:0] rd_q;
  // ==========================================================
  // design and peer
  serial_port_rate_generator DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_srg_clock_in(ext_clk), .rx_frame_sync(frame_sync), .tx_copy_pulse(tx_copy_pulse),
    .gen_bit_clock(bclk), .gen_frame_pulse(fpulse), .rx_reset_n(rx_reset_n),
    .tx_reset_n(tx_reset_n), .tx_frame_sync_out(fs_out), .tx_frame_sync_oe(fs_oe),
    .rx_data_clock_out(rck), .rx_data_clock_oe(rck_oe), .tx_data_clock_out(tck),
    .tx_data_clock_oe(tck_oe));
  ext_serial_peer #(.HALF_NS(80)) peer (.run(run), .fs_go(fs_go), .ext_clk(ext_clk),
    .frame_sync(frame_sync));
  // ==========================================================
  // common tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  // generator held in reset while reprogrammed, two clock cycles before release
  task automatic cfg(input logic [31:0] c, input logic [31:0] ctl);
    wr(`SRG_CTL_ADDR, 32'h0);
    wr(`SRG_CFG_ADDR, c);
    repeat (2) @(posedge clock);
    wr(`SRG_CTL_ADDR, ctl);
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  // high and low length of one bit clock period, bounded
  task automatic meas();
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (bclk !== 1'b0 && n < 3000) begin step(); n++; end
    while (bclk !== 1'b1 && n < 3000) begin step(); n++; end
    while (bclk === 1'b1 && n < 3000) begin step(); n++; hi++; end
    while (bclk === 1'b0 && n < 3000) begin step(); n++; lo++; end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    int ones;
    ones = 0;
    rd(`SRG_CFG_ADDR);
    chk("config reset", 32'h2000_0001, rd_q);
    step();
    chk("read data one cycle", 32'h0, reg_rdata);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C);
    chk("unmapped read", 32'h0, rd_q);
    rd(`SRG_CFG_ADDR);
    chk("config after unmapped write", 32'h2000_0001, rd_q);
    repeat (40) begin step(); ones += (bclk !== 1'b0) + (fpulse !== 1'b0); end
    chk("outputs while held", 32'h0, ones);
    wr(`SRG_CTL_ADDR, 32'hFFFF_FF80);
    rd(`SRG_CTL_ADDR);
    chk("control mask", 32'h0, rd_q);
    rd(`SRG_STAT_ADDR);
    chk("status held", 32'h0, rd_q);
    $display("done reset test");
  endtask
  task automatic t_div();
    logic [7:0] d;
    int ones;
    ones = 0;
    for (int i = 1; i <= 4; i++) begin
      d = 8'(i);
      cfg(32'hE000_0000 | 32'(d), 32'h1);
      meas();
      chk("bit clock high", (d >> 1) + 1, hi);
      chk("bit clock low", d - (d >> 1), lo);
    end
    cfg(32'h2000_0000, 32'h1);
    repeat (5) step();
    repeat (40) begin step(); ones += (bclk !== 1'b1); end
    chk("divisor zero held high", 32'h0, ones);
    $display("done divider test");
  endtask
  task automatic t_frame();
    int r, r0, r1, rf;
    logic pb, pf, bad;
    r = 0;
    r0 = -1;
    r1 = -1;
    rf = -1;
    bad = 1'b0;
    cfg(32'h3004_0101, 32'h1);
    repeat (10) step();
    wr(`SRG_CTL_ADDR, 32'h7F);
    #1 pb = bclk;
    pf = fpulse;
    repeat (200) begin
      step();
      if (bclk === 1'b1 && pb === 1'b0) r++;
      if (fpulse === 1'b1 && pf === 1'b0) begin if (r0 < 0) r0 = r; else if (r1 < 0) r1 = r; end
      if (fpulse === 1'b0 && pf === 1'b1 && rf < 0) rf = r;
      if (fs_out !== pf || rck !== bclk || tck !== bclk) bad = 1'b1;
      pb = bclk;
      pf = fpulse;
    end
    chk("first pulse rise", 32'd8, r0);
    chk("pulse width", 32'd2, rf - r0);
    chk("pulse period", 32'd5, r1 - r0);
    chk("pins follow generator", 32'h0, {31'h0, bad});
    chk("pin enables", 32'h7, {29'h0, fs_oe, rck_oe, tck_oe});
    chk("section enables", 32'h3, {30'h0, rx_reset_n, tx_reset_n});
    rd(`SRG_STAT_ADDR);
    chk("status running", 32'h4, rd_q & 32'h4);
    // copy mode needs no frame generator, only the frame sync pin direction set
    cfg(32'h2004_0101, 32'h19);
    @(posedge clock);
    tx_copy_pulse <= 1'b1;
    @(posedge clock);
    tx_copy_pulse <= 1'b0;
    #1 chk("copy pulse frame", 32'h1, {31'h0, fs_out});
    step();
    chk("copy pulse ends", 32'h0, {31'h0, fs_out});
    $display("done frame test");
  endtask
  task automatic t_ext();
    int n;
    bit seen;
    run = 1'b1;
    cfg(32'h0000_0001, 32'h1);
    meas();
    chk("ext high", 32'd16, hi);
    chk("ext low", 32'd16, lo);
    chk("rising edge phase", 32'h1, {31'h0, ext_clk});
    cfg(32'h4000_0001, 32'h1);
    meas();
    chk("falling edge phase", 32'h0, {31'h0, ext_clk});
    cfg(32'h8002_0001, 32'h1);
    repeat (80) step();
    wr(`SRG_CTL_ADDR, 32'h3);
    seen = 0;
    repeat (700) begin step(); seen |= (fpulse === 1'b1); end
    chk("no pulse without sync", 32'h0, {31'h0, seen});
    fs_go = 1'b1;
    n = 0;
    while (fpulse !== 1'b1 && n < 300) begin step(); n++; end
    fs_go = 1'b0;
    chk("pulse after sync", 32'h1, {31'h0, fpulse});
    chk("clock restarts high", 32'h1, {31'h0, bclk});
    run = 1'b0;
    $display("done external test");
  endtask
  // ==========================================================
  // clock, watchdog, verdict
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_div();
    t_frame();
    t_ext();
    results();
  end
endmodule // tb_serial_port_rate_generator
